// >>> rsb_spi.v
`timescale 1ns/1ps
`default_nettype none
`include "rsb_defines.vh"
// =====================================================
// Serial register-access port with two banks
module rsb_spi #(
  parameter NB = 5  // Bytes held per register
) (
  input  wire       MCLK,
  input  wire       RSTN,
  input  wire       CHIP_SELECT_N,
  input  wire       SCK,
  input  wire       MOSI,
  output reg        MISO,
  output wire       MISO_OE_N,
  input  wire       STANDBY,
  input  wire       RX_READY_EVENT,
  input  wire       TX_SENT_EVENT,
  input  wire       RETRY_LIMIT_EVENT,
  output reg        IRQ_N,
  output wire [7:0] RADIO_CONFIG,
  output wire       BANK_SEL,
  output wire       FEATURES_ON
);

  // =====================================================
  // States
  localparam [5:0] ST_IDLE = 6'b00_0001;  // Deselected
  localparam [5:0] ST_CMD  = 6'b00_0010;  // Command byte
  localparam [5:0] ST_RD   = 6'b00_0100;  // Register read
  localparam [5:0] ST_WR   = 6'b00_1000;  // Register write
  localparam [5:0] ST_ACT  = 6'b01_0000;  // Activation data
  localparam [5:0] ST_SKIP = 6'b10_0000;  // Ignore rest
  localparam integer LAST_N = NB - 1;     // Highest byte index
  localparam [2:0] LAST_IX = LAST_N[2:0]; // Same, at index width

  // =====================================================
  // Pin synchronisers, three stages, 2nd/3rd agree
  reg  [2:0] cs_s;   // Select sync
  reg  [2:0] ck_s;   // Clock sync
  reg  [2:0] di_s;   // Data sync
  reg        cs_q;   // Filtered select
  reg        ck_q;   // Filtered clock
  reg        di_q;   // Filtered data
  wire       ck_new = (ck_s[1] == ck_s[2]) ? ck_s[2] : ck_q;
  wire       cs_new = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_q;
  wire       rise = ck_new & ~ck_q & ~cs_q;  // Ignored while deselected
  wire       fall = ~ck_new & ck_q & ~cs_q;
  wire       cs_fall = ~cs_new & cs_q;

  // Sync chains and filters
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      cs_s <= 3'h7;
      ck_s <= 3'h0;
      di_s <= 3'h0;
      cs_q <= 1'b1;
      ck_q <= 1'b0;
      di_q <= 1'b0;
    end else begin
      cs_s <= {cs_s[1:0], CHIP_SELECT_N};
      ck_s <= {ck_s[1:0], SCK};
      di_s <= {di_s[1:0], MOSI};
      cs_q <= cs_new;
      ck_q <= ck_new;
      if (di_s[1] == di_s[2]) begin
        di_q <= di_s[2];
      end
    end
  end

  // =====================================================
  // Transaction state
  reg  [5:0] st_q;     // Current state
  reg  [2:0] bit_q;    // Bits of current byte
  reg  [2:0] ix_q;     // Data byte index
  reg  [4:0] addr_q;   // Register address
  reg  [6:0] rx_q;     // Incoming bits
  reg  [7:0] tx_q;     // Outgoing shifter
  reg        bank_q;   // Active bank
  reg        feat_q;   // Optional features on
  reg  [7:0] cfg_q;    // Configuration register
  reg  [7:0] stat_q;   // Sticky event bits
  wire [7:0] byte_in = {rx_q, di_q};  // Completed byte
  wire       done = rise & (bit_q == 3'h7);

  // Byte order: bank-1 low registers reversed
  wire       rev = bank_q & (addr_q <= `RSB_REV_LAST);
  wire [2:0] phys = rev ? (LAST_IX - ix_q) : ix_q;
  wire       in_rng = (ix_q <= LAST_IX);
  wire [8:0] maddr = {bank_q, addr_q, phys};
  wire [7:0] mdata;
  wire       spec_cfg = ~bank_q & (addr_q == `RSB_REG_CONFIG);
  wire       spec_st = ~bank_q & (addr_q == `RSB_REG_STATUS);
  wire       mwe = done & st_q[3] & in_rng & ~spec_cfg & ~spec_st;

  // Live status view with bank flag
  wire [7:0] stat_view = {bank_q, stat_q[6:0]};

  // Read byte selection
  reg  [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (!in_rng) begin
      rd_byte = 8'h00;                 // Past register end
    end else if (spec_cfg) begin
      rd_byte = (ix_q == 3'h0) ? cfg_q : 8'h00;
    end else if (spec_st) begin
      rd_byte = (ix_q == 3'h0) ? stat_view : 8'h00;
    end else begin
      rd_byte = mdata;
    end
  end

  rsb_mem #(
    .AW(9),
    .DW(8)
  ) u_mem (
    .clk   (MCLK),
    .we    (mwe),
    .waddr (maddr),
    .wdata (byte_in),
    .raddr (maddr),
    .rdata (mdata)
  );

  // Command decode into next state
  reg  [5:0] cmd_st;
  always @* begin
    cmd_st = ST_SKIP;
    if (byte_in[7:5] == `RSB_OP_READ) begin
      cmd_st = ST_RD;
    end else if (byte_in[7:5] == `RSB_OP_WRITE) begin
      cmd_st = STANDBY ? ST_WR : ST_SKIP;
    end else if (byte_in == `RSB_CMD_ACTIVATE) begin
      cmd_st = STANDBY ? ST_ACT : ST_SKIP;
    end else if (byte_in == `RSB_CMD_NO_ACTION) begin
      cmd_st = ST_SKIP;
    end else begin
      cmd_st = ST_SKIP;                // Outside this block
    end
  end

  // Frame sequencing and shifters
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q   <= ST_IDLE;
      bit_q  <= 3'h0;
      ix_q   <= 3'h0;
      addr_q <= 5'h00;
      rx_q   <= 7'h00;
      tx_q   <= 8'h00;
      bank_q <= 1'b0;
      feat_q <= 1'b0;
      MISO   <= 1'b0;
    end else if (cs_q) begin
      st_q  <= ST_IDLE;                // Deselected: hold idle
      bit_q <= 3'h0;
      if (cs_fall) begin
        st_q <= ST_CMD;
        tx_q <= stat_view;
        MISO <= stat_view[7];
      end
    end else begin
      if (rise) begin
        rx_q  <= byte_in[6:0];
        bit_q <= bit_q + 3'h1;
      end
      if (done) begin
        case (st_q)
          ST_CMD: begin
            st_q   <= cmd_st;
            addr_q <= byte_in[4:0];
            ix_q   <= 3'h0;
          end
          ST_RD, ST_WR: begin
            if (in_rng) begin
              ix_q <= ix_q + 3'h1;     // Next byte, stop past end
            end
          end
          ST_ACT: begin
            if (byte_in == `RSB_ACT_BANK) begin
              bank_q <= ~bank_q;
            end
            if (byte_in == `RSB_ACT_FEATURES) begin
              feat_q <= ~feat_q;
            end
            st_q <= ST_SKIP;
          end
          default: begin
            st_q <= st_q;
          end
        endcase
      end
      if (fall) begin
        if (bit_q == 3'h0) begin
          // Byte boundary: next outgoing byte
          tx_q <= st_q[2] ? rd_byte : 8'h00;
          MISO <= st_q[2] ? rd_byte[7] : 1'b0;
        end else begin
          tx_q <= {tx_q[6:0], 1'b0};
          MISO <= tx_q[6];
        end
      end
    end
  end

  // =====================================================
  // Configuration and sticky status
  wire [2:0] ev = {RX_READY_EVENT, TX_SENT_EVENT, RETRY_LIMIT_EVENT};
  wire       wr0 = mwe | (done & st_q[3] & in_rng & (ix_q == 3'h0));
  wire [2:0] clr = (wr0 & spec_st) ? byte_in[6:4] : 3'h0;

  // Config writes, event set wins over clear
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_q  <= `RSB_CONFIG_RESET;
      stat_q <= `RSB_STATUS_RESET;
      IRQ_N  <= 1'b1;
    end else begin
      if (wr0 & spec_cfg) begin
        cfg_q <= byte_in & `RSB_CONFIG_WMASK;
      end
      stat_q[6:4] <= (stat_q[6:4] & ~clr) | ev;
      IRQ_N <= ~((stat_q[6] & ~cfg_q[`RSB_BIT_RX_MASK])
               | (stat_q[5] & ~cfg_q[`RSB_BIT_TX_MASK])
               | (stat_q[4] & ~cfg_q[`RSB_BIT_RT_MASK]));
    end
  end

  assign MISO_OE_N    = cs_q;          // Drive only while selected
  assign RADIO_CONFIG = cfg_q;
  assign BANK_SEL     = bank_q;
  assign FEATURES_ON  = feat_q;

endmodule
`default_nettype wire

// >>> rsb_defines.vh
//
// Contract
// - Bank 0, bank-1 9..14: LSB byte first
// - Bank-1 registers 0..8: MSB byte first
// - Status bits shift out during command byte
// - Activation plus 0x53 swaps register bank
// - Active bank readable in register 7 bit 7; code does so in bank 0 only, bank-1 register 7 is plain storage
// - Bit 6 masks receive-ready from interrupt
// - Bit 5 masks transmit-sent from interrupt
// - Bit 4 masks retry-limit from interrupt
// - Activation opcode 0x50, 0x73 toggles features
// - Read 000AAAAA, write 001AAAAA, writes standby-only
// - All-ones command does nothing, returns status
`ifndef RSB_DEFINES_VH
`define RSB_DEFINES_VH

// =====================================================
// Command encodings
`define RSB_OP_READ        3'h0
`define RSB_OP_WRITE       3'h1
`define RSB_CMD_ACTIVATE   8'h50
`define RSB_CMD_NO_ACTION  8'hFF
`define RSB_ACT_BANK       8'h53
`define RSB_ACT_FEATURES   8'h73

// =====================================================
// Register addresses and fields
`define RSB_REG_CONFIG     5'h00
`define RSB_REG_STATUS     5'h07
`define RSB_REV_LAST       5'h08
`define RSB_BIT_BANK       7
`define RSB_BIT_RX_MASK    6
`define RSB_BIT_TX_MASK    5
`define RSB_BIT_RT_MASK    4
`define RSB_CONFIG_WMASK   8'h7F
`define RSB_CONFIG_RESET   8'h08
`define RSB_STATUS_RESET   8'h00

`endif

// >>> rsb_mem.v
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Register storage, one write port, registered read
module rsb_mem #(
  parameter AW = 9,
  parameter DW = 8
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];  // Byte array

  // Write and registered read
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// >>> rsb_spi_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Pin-level checker for the register port
module rsb_spi_chk (
  input wire logic       MCLK,
  input wire logic       RSTN,
  input wire logic       CHIP_SELECT_N,
  input wire logic       STANDBY,
  input wire logic       RX_READY_EVENT,
  input wire logic       TX_SENT_EVENT,
  input wire logic       RETRY_LIMIT_EVENT,
  input wire logic       MISO_OE_N,
  input wire logic       IRQ_N,
  input wire logic [7:0] RADIO_CONFIG,
  input wire logic       BANK_SEL,
  input wire logic       FEATURES_ON
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Settled select levels and a long run out of standby
  sequence s_desel; CHIP_SELECT_N [*6]; endsequence
  sequence s_sel; !CHIP_SELECT_N [*6]; endsequence
  sequence s_busy; !STANDBY [*8]; endsequence
  // Unmasked event pulls the pin low within two cycles
  property p_irq(ev, msk);
    ev && !msk |-> ##[1:2] !IRQ_N;
  endproperty
  AST_OE_DESEL: assert property (s_desel |-> MISO_OE_N)
    else $error("output enabled while deselected");
  AST_OE_SEL: assert property (s_sel |-> !MISO_OE_N)
    else $error("output idle while selected");
  AST_CFG_IDLE: assert property (s_desel |-> $stable(RADIO_CONFIG))
    else $error("config changed outside a frame");
  AST_BANK_IDLE: assert property (s_desel |-> $stable({BANK_SEL, FEATURES_ON}))
    else $error("bank or features changed outside a frame");
  AST_LOCKED: assert property (s_busy |-> $stable({RADIO_CONFIG, BANK_SEL, FEATURES_ON}))
    else $error("write taken outside standby");
  AST_IRQ_RX: assert property (p_irq(RX_READY_EVENT, RADIO_CONFIG[6]))
    else $error("rx event did not raise irq");
  AST_IRQ_TX: assert property (p_irq(TX_SENT_EVENT, RADIO_CONFIG[5]))
    else $error("tx event did not raise irq");
  AST_IRQ_RT: assert property (p_irq(RETRY_LIMIT_EVENT, RADIO_CONFIG[4]))
    else $error("retry event did not raise irq");
  AST_IRQ_MASKED: assert property ((RADIO_CONFIG[6:4] == 3'h7) [*3] |-> IRQ_N)
    else $error("irq low with all sources masked");
endmodule
bind rsb_spi rsb_spi_chk chk (.MCLK(MCLK), .RSTN(RSTN), .CHIP_SELECT_N(CHIP_SELECT_N),
  .STANDBY(STANDBY), .RX_READY_EVENT(RX_READY_EVENT), .TX_SENT_EVENT(TX_SENT_EVENT),
  .RETRY_LIMIT_EVENT(RETRY_LIMIT_EVENT), .MISO_OE_N(MISO_OE_N), .IRQ_N(IRQ_N),
  .RADIO_CONFIG(RADIO_CONFIG), .BANK_SEL(BANK_SEL), .FEATURES_ON(FEATURES_ON));
`default_nettype wire

// >>> rsb_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host master, mode 0, 80 ns serial clock
module rsb_host (
  input wire logic clk,
  output var logic cs_n,
  output var logic sck,
  output var logic mosi,
  input wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // One frame: nb bits from the top of tx, replies shifted into rx
  task automatic xfer(input int nb, input logic [47:0] tx, output logic [47:0] rx);
    rx = '0;
    @(negedge clk) cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      mosi = tx[47-i];
      repeat (8) @(negedge clk);
      sck = 1'b1;
      rx = {rx[46:0], miso};
      repeat (8) @(negedge clk);
      sck = 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (12) @(negedge clk);
  endtask
  // Serial clock bursts with the select released, must be ignored
  task automatic idle_clk(input int n);
    for (int i = 0; i < n; i++) begin
      mosi = i[0];
      repeat (8) @(negedge clk);
      sck = 1'b1;
      repeat (8) @(negedge clk);
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> rsb_spi_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the register port
module rsb_spi_bench;
  logic        mclk;
  logic        rstn;
  logic        standby;
  logic [2:0]  ev;      // Rx, tx, retry pulses
  logic [47:0] rx;      // Last frame reply
  int          errors;
  int          samples_checked;
  wire         cs_n, sck, mosi, miso, oe_n, irq_n, bank, feat;
  wire  [7:0]  cfg;
  rsb_host host (.clk(mclk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
  rsb_spi #(.NB(5)) uut (.MCLK(mclk), .RSTN(rstn), .CHIP_SELECT_N(cs_n), .SCK(sck),
    .MOSI(mosi), .MISO(miso), .MISO_OE_N(oe_n), .STANDBY(standby),
    .RX_READY_EVENT(ev[2]), .TX_SENT_EVENT(ev[1]), .RETRY_LIMIT_EVENT(ev[0]),
    .IRQ_N(irq_n), .RADIO_CONFIG(cfg), .BANK_SEL(bank), .FEATURES_ON(feat));
  task chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Command plus one data byte
  task wr(input logic [7:0] c, input logic [7:0] d);
    host.xfer(16, {c, d, 32'h0000_0000}, rx);
  endtask
  task pulse(input logic [2:0] v);
    @(negedge mclk) ev = v;
    @(negedge mclk) ev = 3'h0;
    repeat (3) @(negedge mclk);
  endtask
  task complete_run;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Writes and activation refused outside standby
  task t_refused;
    standby = 1'b0;
    wr(8'h20, 8'h70);
    wr(8'h50, 8'h53);
    chk({cfg, bank}, {8'h08, 1'b0});
    standby = 1'b1;
  endtask
  // Each source alone unmasked, the other two masked
  task t_irq;
    logic [2:0] v;
    for (int k = 0; k < 3; k++) begin
      v = 3'h4 >> k;
      wr(8'h20, {1'b0, ~v, 4'h0});
      chk(cfg, {1'b0, ~v, 4'h0});
      pulse(~v);
      chk(irq_n, 1'b1);
      wr(8'hFF, 8'h00);
      chk(rx[15:8], {1'b0, ~v, 4'h0});
      pulse(v);
      chk(irq_n, 1'b0);
      wr(8'h27, 8'h70);
      chk(rx[15:8], 8'h70);
      chk(irq_n, 1'b1);
    end
  endtask
  // Bank-0 byte order, reserved bit, masks, idle clocks, foreign opcode
  task t_misc;
    host.xfer(32, {8'h2A, 8'h11, 8'h22, 8'h33, 16'h0000}, rx);
    chk(uut.u_mem.mem[9'h050], 8'h11);
    chk(uut.u_mem.mem[9'h052], 8'h33);
    host.xfer(32, {8'h0A, 40'h00_0000_0000}, rx);
    chk(rx[23:0], 24'h11_2233);
    wr(8'h20, 8'hF0);
    chk(cfg, 8'h70);
    pulse(3'h7);
    chk(irq_n, 1'b1);
    host.idle_clk(5);
    wr(8'h00, 8'h00);
    chk(rx[15:0], 16'h7070);
    wr(8'hE1, 8'h55);
    chk(rx[15:0], 16'h7000);
    wr(8'h20, 8'h00);
    chk(irq_n, 1'b0);
    wr(8'h27, 8'h70);
    chk(irq_n, 1'b1);
  endtask
  // Bank swap, reversed bytes in bank 1, feature toggle
  task t_bank;
    wr(8'h50, 8'h53);
    chk(bank, 1'b1);
    wr(8'hFF, 8'h00);
    chk(rx[15:8], 8'h80);
    host.xfer(24, {8'h28, 8'hA1, 8'hB2, 24'h00_0000}, rx);
    host.xfer(24, {8'h08, 40'h00_0000_0000}, rx);
    chk(rx[15:0], 16'hA1B2);
    chk(uut.u_mem.mem[9'h144], 8'hA1);
    host.xfer(24, {8'h29, 8'hC3, 8'hD4, 24'h00_0000}, rx);
    chk(uut.u_mem.mem[9'h148], 8'hC3);
    wr(8'h50, 8'h73);
    chk(feat, 1'b1);
    wr(8'h50, 8'h53);
    wr(8'h07, 8'h00);
    chk(rx[7:0], 8'h00);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    rstn = 1'b0;
    standby = 1'b1;
    ev = 3'h0;
    errors = 0;
    samples_checked = 0;
    repeat (20) @(negedge mclk);
    chk({cfg, bank, feat, irq_n, oe_n}, {8'h08, 4'h3});
    rstn = 1'b1;
    repeat (8) @(negedge mclk);
    t_refused();
    t_irq();
    t_misc();
    t_bank();
    complete_run();
  end
  // Watchdog against a hung run
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
